// file: inc/sensor_i2c_pkg.sv
/*
  Constants and state types of the sensor serial register port.
  Assumes a 20 MHz system clock and a separate link sampling clock.
*/
package sensor_i2c_pkg;

  // Bus addresses of the device, write and read forms.
  localparam logic [7:0] DEV_ADDR_WR = 8'h94;
  localparam logic [7:0] DEV_ADDR_RD = 8'h95;

  // Register indices.
  localparam int NREG = 22;
  localparam int RIDX_W = 5;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MAIN = 8'h01;
  localparam logic [7:0] REG_RXCFG = 8'h02;
  localparam logic [7:0] REG_TXCFG = 8'h03;
  localparam logic [7:0] REG_ALS_HI = 8'h04;
  localparam logic [7:0] REG_ALS_LO = 8'h05;
  localparam logic [7:0] REG_PERSIST = 8'h0a;
  localparam logic [7:0] REG_TRIM_G = 8'h0f;
  localparam logic [7:0] REG_TRIM_IR = 8'h10;
  localparam logic [7:0] REG_PROXIMITY = 8'h15;
  localparam logic [7:0] REG_RSVD_LO = 8'hf6;
  localparam logic [7:0] PTR_TOP = 8'hff;

  // Read and reset values.
  localparam logic [7:0] RD_BEYOND = 8'hff;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  localparam logic [7:0] RESET_TRIM = 8'h80;
  localparam logic [2:0] RESET_STATUS = 3'h4;

  // Status bit positions.
  localparam int ST_ALS = 0;
  localparam int ST_PROXIMITY = 1;
  localparam int ST_POWER_ON_FLAG = 2;

  // Main configuration fields.
  localparam int MAIN_ALS_IE = 0;
  localparam int MAIN_PROXIMITY_IE = 1;
  localparam int MAIN_MODE_LSB = 2;
  localparam int MAIN_TRIM = 5;
  localparam logic [2:0] MODE_ALS_PROXIMITY = 3'h4;

  // Receive configuration for highest gain and 14-bit conversion.
  localparam logic [7:0] RX_GAIN_MAX_14B = 8'hf0;

  // Bus timing figures.
  localparam int SCL_MAX_KHZ = 400;
  localparam int SCL_PERIOD_NS = 1000000 / SCL_MAX_KHZ;
  localparam int CLK_MHZ = 20;
  localparam int SCL_PERIOD_CYC = SCL_PERIOD_NS * CLK_MHZ / 1000;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  typedef enum logic [2:0] {
    PH_IDLE, PH_ADDR, PH_PTR, PH_WDATA, PH_RDATA, PH_IGNORE
  } link_phase_t;

  typedef struct packed {
    link_phase_t phase;
    logic sclS1;
    logic sclS2;
    logic sclD;
    logic sdaS1;
    logic sdaS2;
    logic sdaD;
    logic busy;
    logic rep;
    logic startHi;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic [7:0] rdLatch;
    logic sdaOe;
    logic reqTgl;
    logic reqWr;
    logic [7:0] reqAddr;
    logic [7:0] reqData;
    logic ackS1;
    logic ackS2;
    logic ackD;
  } link_state_t;

  typedef struct packed {
    logic reqS1;
    logic reqS2;
    logic reqD;
    logic ackTgl;
    logic [7:0] rdData;
    logic [2:0] status;
    logic intOe;
    logic [NREG-1:0][7:0] regs;
  } sys_state_t;

endpackage

// file: core/sensor_i2c_register_port.sv
/*
  Two-wire serial slave port and register file of a light and proximity sensor.
  Assumes linkClk oversamples SCL and SDA at least 8 times per SCL phase,
  that the pad combines sdaOut/sdaOe and intOut/intOe as open-drain,
  and that alsEvent and proxEvent are one-cycle pulses on clk.
*/
`timescale 1ns/1ps

module sensor_i2c_register_port
  import sensor_i2c_pkg::*;
#(
  parameter bit REV_ONE = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic linkClk,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic intOut,
  output logic intOe,
  input wire logic alsEvent,
  input wire logic proxEvent,
  input wire logic [15:0] alsResult,
  input wire logic [7:0] proxResult,
  output logic [7:0] mainCfg,
  output logic [7:0] rxCfg,
  output logic [7:0] txCfg,
  output logic [7:0] persistCfg,
  output logic alsIntEn,
  output logic proxIntEn,
  output logic alsProxMode,
  output logic trimSel,
  output logic alsGainMax14
);

  link_state_t link_r;
  link_state_t link_nxt;
  sys_state_t sys_r;
  sys_state_t sys_nxt;

  // Next pointer value; it sticks at the top so reads past it repeat 0xFF.
  function automatic logic [7:0] ptrInc(input logic [7:0] p);
    ptrInc = (p == PTR_TOP) ? p : p + 8'h01;
  endfunction

  // Registers the host may store into; status and results are read-only.
  function automatic logic isWritable(input logic [7:0] a);
    isWritable = (a < 8'(NREG)) && (a != REG_STATUS) && (a != REG_ALS_HI) &&
                 (a != REG_ALS_LO) && (a != REG_PROXIMITY);
  endfunction

  // Link side: sampling, framing, shifting and pointer handling.
  always_comb begin
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic dn;
    dn = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    link_nxt = link_r;
    // Two-stage samplers; the second stage and a delayed copy of it are looked at.
    link_nxt.sclS1 = sclIn;
    link_nxt.sclS2 = link_r.sclS1;
    link_nxt.sclD = link_r.sclS2;
    link_nxt.sdaS1 = sdaIn;
    link_nxt.sdaS2 = link_r.sdaS1;
    link_nxt.sdaD = link_r.sdaS2;
    link_nxt.ackS1 = sys_r.ackTgl;
    link_nxt.ackS2 = link_r.ackS1;
    link_nxt.ackD = link_r.ackS2;
    rise = link_r.sclS2 && !link_r.sclD;
    fall = !link_r.sclS2 && link_r.sclD;
    start = link_r.sclS2 && link_r.sclD && link_r.sdaD && !link_r.sdaS2;
    stop = link_r.sclS2 && link_r.sclD && !link_r.sdaD && link_r.sdaS2;
    // The SCL fall that closes a START's high phase is not a bit clock.
    dn = fall && !link_r.startHi;
    // Read data crosses as a word held still until the answer toggle flips.
    if (link_r.ackS2 != link_r.ackD) begin
      link_nxt.rdLatch = sys_r.rdData;
    end
    if (fall) begin
      link_nxt.startHi = 1'b0;
    end
    if (start) begin
      link_nxt.phase = PH_ADDR;
      link_nxt.bitCnt = 4'h0;
      link_nxt.sdaOe = 1'b0;
      link_nxt.rep = link_r.busy;
      link_nxt.busy = 1'b1;
      link_nxt.startHi = 1'b1;
    end else if (stop && !link_r.startHi) begin
      link_nxt.phase = PH_IDLE;
      link_nxt.busy = 1'b0;
      link_nxt.sdaOe = 1'b0;
    end else begin
      case (link_r.phase)
        PH_ADDR, PH_PTR, PH_WDATA: begin
          if (rise && link_r.bitCnt < ACK_SLOT) begin
            link_nxt.shift = {link_r.shift[6:0], link_r.sdaS2};
          end
          if (dn && link_r.bitCnt < LAST_BIT) begin
            link_nxt.bitCnt = link_r.bitCnt + 4'h1;
          end else if (dn && link_r.bitCnt == LAST_BIT) begin
            // A whole byte is in; acknowledge through the ninth clock.
            link_nxt.bitCnt = ACK_SLOT;
            link_nxt.sdaOe = 1'b1;
            case (link_r.phase)
              PH_ADDR: begin
                if (link_r.shift == DEV_ADDR_WR) begin
                  link_nxt.phase = PH_PTR;
                end else if (link_r.shift == DEV_ADDR_RD) begin
                  link_nxt.phase = PH_RDATA;
                  // Plain START reads from zero, repeated START keeps the preset pointer.
                  link_nxt.ptr = link_r.rep ? link_r.ptr : REG_STATUS;
                  link_nxt.reqAddr = link_r.rep ? link_r.ptr : REG_STATUS;
                  link_nxt.reqWr = 1'b0;
                  link_nxt.reqTgl = !link_r.reqTgl;
                end else begin
                  link_nxt.phase = PH_IGNORE;
                  link_nxt.sdaOe = 1'b0;
                end
              end
              PH_PTR: begin
                link_nxt.ptr = link_r.shift;
                link_nxt.phase = PH_WDATA;
              end
              default: begin
                link_nxt.reqAddr = link_r.ptr;
                link_nxt.reqData = link_r.shift;
                link_nxt.reqWr = 1'b1;
                link_nxt.reqTgl = !link_r.reqTgl;
                link_nxt.ptr = ptrInc(link_r.ptr);
              end
            endcase
          end else if (dn && link_r.bitCnt == ACK_SLOT) begin
            link_nxt.sdaOe = 1'b0;
            link_nxt.bitCnt = 4'h0;
          end
        end
        PH_RDATA: begin
          if (rise && link_r.bitCnt == ACK_SLOT && !link_r.sdaOe && link_r.sdaS2) begin
            // The master declined the byte; stay off the bus until a new frame.
            link_nxt.phase = PH_IGNORE;
          end else if (fall && link_r.bitCnt == ACK_SLOT) begin
            // Put the first bit out on the falling edge so it is settled at the rise.
            link_nxt.shift = link_r.rdLatch;
            link_nxt.sdaOe = !link_r.rdLatch[7];
            link_nxt.bitCnt = 4'h0;
          end else if (fall && link_r.bitCnt < LAST_BIT) begin
            link_nxt.shift = {link_r.shift[6:0], 1'b1};
            link_nxt.sdaOe = !link_r.shift[6];
            link_nxt.bitCnt = link_r.bitCnt + 4'h1;
          end else if (fall && link_r.bitCnt == LAST_BIT) begin
            // Free SDA for the master's acknowledge and fetch the next register.
            link_nxt.sdaOe = 1'b0;
            link_nxt.bitCnt = ACK_SLOT;
            link_nxt.ptr = ptrInc(link_r.ptr);
            link_nxt.reqAddr = ptrInc(link_r.ptr);
            link_nxt.reqWr = 1'b0;
            link_nxt.reqTgl = !link_r.reqTgl;
          end
        end
        PH_IGNORE: begin
          link_nxt.sdaOe = 1'b0;
        end
        default: begin
          link_nxt.sdaOe = 1'b0;
        end
      endcase
    end
  end

  // Link state register on the link's own clock.
  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      link_r <= '{phase: PH_IDLE, sclS1: 1'b1, sclS2: 1'b1, sclD: 1'b1,
                  sdaS1: 1'b1, sdaS2: 1'b1, sdaD: 1'b1, default: '0};
    end else begin
      link_r <= link_nxt;
    end
  end

  // System side: request service, register file and interrupt status.
  always_comb begin
    logic take;
    logic [2:0] setBits;
    logic [2:0] clrBits;
    logic [RIDX_W-1:0] idx;
    logic [7:0] rd;
    take = 1'b0;
    setBits = 3'h0;
    clrBits = 3'h0;
    idx = link_r.reqAddr[RIDX_W-1:0];
    rd = RD_UNMAPPED;
    sys_nxt = sys_r;
    sys_nxt.reqS1 = link_r.reqTgl;
    sys_nxt.reqS2 = sys_r.reqS1;
    sys_nxt.reqD = sys_r.reqS2;
    take = sys_r.reqS2 != sys_r.reqD;
    // Events are caught only while their interrupt is enabled.
    setBits[ST_ALS] = alsEvent && sys_r.regs[REG_MAIN][MAIN_ALS_IE];
    setBits[ST_PROXIMITY] = proxEvent && sys_r.regs[REG_MAIN][MAIN_PROXIMITY_IE];
    clrBits[ST_ALS] = !sys_r.regs[REG_MAIN][MAIN_ALS_IE];
    clrBits[ST_PROXIMITY] = !sys_r.regs[REG_MAIN][MAIN_PROXIMITY_IE];
    if (take && link_r.reqWr) begin
      if (isWritable(link_r.reqAddr)) begin
        sys_nxt.regs[idx] = link_r.reqData;
      end
    end else if (take) begin
      // Read decode; trim registers return the complement of what they hold.
      if (link_r.reqAddr >= REG_RSVD_LO) begin
        rd = RD_BEYOND;
      end else if (link_r.reqAddr == REG_STATUS) begin
        rd = {5'h00, sys_r.status};
        clrBits = 3'h7;
      end else if (link_r.reqAddr == REG_ALS_HI) begin
        rd = alsResult[15:8];
      end else if (link_r.reqAddr == REG_ALS_LO) begin
        rd = alsResult[7:0];
      end else if (link_r.reqAddr == REG_PROXIMITY) begin
        rd = proxResult;
      end else if (link_r.reqAddr == REG_TRIM_G || link_r.reqAddr == REG_TRIM_IR) begin
        rd = ~sys_r.regs[idx];
      end else if (link_r.reqAddr < 8'(NREG)) begin
        rd = sys_r.regs[idx];
      end
      sys_nxt.rdData = rd;
    end
    if (take) begin
      sys_nxt.ackTgl = !sys_r.ackTgl;
    end
    // A new event wins over a clear in the same cycle.
    sys_nxt.status = (sys_r.status & ~clrBits) | setBits;
    sys_nxt.intOe = sys_nxt.status[ST_ALS] || sys_nxt.status[ST_PROXIMITY] ||
                    (sys_nxt.status[ST_POWER_ON_FLAG] && !REV_ONE);
  end

  // System state register; the power-on flag starts set.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_r <= '{status: RESET_STATUS, intOe: !REV_ONE, default: '0};
      sys_r.regs[REG_TRIM_G[RIDX_W-1:0]] <= RESET_TRIM;
      sys_r.regs[REG_TRIM_IR[RIDX_W-1:0]] <= RESET_TRIM;
    end else begin
      sys_r <= sys_nxt;
    end
  end

  // Open-drain pins only ever pull low; SCL is never driven.
  assign sdaOut = 1'b0;
  assign sdaOe = link_r.sdaOe;
  assign intOut = 1'b0;
  assign intOe = sys_r.intOe;

  // Configuration seen by the measurement engines.
  assign mainCfg = sys_r.regs[REG_MAIN];
  assign rxCfg = sys_r.regs[REG_RXCFG];
  assign txCfg = sys_r.regs[REG_TXCFG];
  assign persistCfg = sys_r.regs[REG_PERSIST];
  assign alsIntEn = mainCfg[MAIN_ALS_IE];
  assign proxIntEn = mainCfg[MAIN_PROXIMITY_IE];
  assign alsProxMode = mainCfg[MAIN_MODE_LSB+2:MAIN_MODE_LSB] == MODE_ALS_PROXIMITY;
  assign trimSel = mainCfg[MAIN_TRIM];
  assign alsGainMax14 = rxCfg == RX_GAIN_MAX_14B;

endmodule

// file: dv/sensor_i2c_register_port_chk.sv
/*
  Concurrent checks on the ports of the sensor serial register port.
  Assumes it is bound into every instance of the design.
*/
`timescale 1ns/1ps
module sensor_i2c_register_port_chk
  import sensor_i2c_pkg::*;
(
  input logic clk,
  input logic rst_n,
  input logic linkClk,
  input logic sclIn,
  input logic sdaOut,
  input logic sdaOe,
  input logic intOut,
  input logic intOe,
  input logic alsEvent,
  input logic proxEvent,
  input logic [7:0] mainCfg,
  input logic [7:0] rxCfg,
  input logic alsIntEn,
  input logic proxIntEn,
  input logic alsProxMode,
  input logic alsGainMax14
);
  // Link side: open-drain SDA that only moves while SCL is low.
  sda_drain_a: assert property (@(posedge linkClk) disable iff (!rst_n)
    sdaOut == 1'b0) else $error("SDA output level is not low.");
  sda_steady_a: assert property (@(posedge linkClk) disable iff (!rst_n)
    sclIn && $past(sclIn) |-> $stable(sdaOe)) else $error("SDA moved while SCL high.");
  ack_hold_a: assert property (@(posedge linkClk) disable iff (!rst_n)
    sdaOe && $rose(sclIn) |=> sdaOe [*8]) else $error("SDA pull dropped early in SCL high.");
  // System side: interrupt pin and decoded configuration levels.
  int_drain_a: assert property (@(posedge clk) disable iff (!rst_n)
    !intOut) else $error("Interrupt output level is not low.");
  int_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(intOe) |-> $past(alsEvent) || $past(proxEvent) || $past(alsEvent, 2) || $past(proxEvent, 2))
    else $error("Interrupt rose without an event.");
  int_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    alsEvent && alsIntEn |-> ##[1:2] intOe) else $error("Enabled event did not raise interrupt.");
  int_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!alsIntEn && !proxIntEn) [*3] |-> !intOe) else $error("Interrupt pending while disabled.");
  en_decode_a: assert property (@(posedge clk) disable iff (!rst_n)
    {proxIntEn, alsIntEn} == mainCfg[1:0] && alsProxMode == (mainCfg[4:2] == MODE_ALS_PROXIMITY))
    else $error("Main configuration decode wrong.");
  gain_decode_a: assert property (@(posedge clk) disable iff (!rst_n)
    alsGainMax14 == (rxCfg == RX_GAIN_MAX_14B)) else $error("Gain decode wrong.");
endmodule
bind sensor_i2c_register_port sensor_i2c_register_port_chk i_chk (
  .clk, .rst_n, .linkClk, .sclIn, .sdaOut, .sdaOe, .intOut, .intOe, .alsEvent,
  .proxEvent, .mainCfg, .rxCfg, .alsIntEn, .proxIntEn, .alsProxMode, .alsGainMax14
);

// file: dv/i2c_host.sv
/*
  Behavioural two-wire bus master that clocks SCL and pulls SDA.
  Assumes the bench resolves SDA with a pull-up and feeds it back.
*/
`timescale 1ns/1ps
module i2c_host (
  output logic scl,
  output logic sdaLow,
  input wire logic sda
);
  // Quarter of a 400 kHz bit period; SCL stands high between frames.
  localparam int Q = 625;
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // Start or repeated start: SDA falls while SCL is high.
  task automatic start();
    #Q sdaLow = 1'b0;
    #Q scl = 1'b1;
    #Q sdaLow = 1'b1;
    #Q scl = 1'b0;
  endtask
  // Stop: SDA rises while SCL is high, then the bus is left released.
  task automatic stop();
    #Q sdaLow = 1'b1;
    #Q scl = 1'b1;
    #Q sdaLow = 1'b0;
    #Q;
  endtask
  // One byte MSB first plus the ninth clock; rel releases SDA on the ninth.
  task automatic xfer(input logic [7:0] d, input logic rel, output logic [7:0] q, output logic nak);
    for (int i = 7; i >= -1; i--) begin
      #Q sdaLow = (i >= 0) ? !d[i] : !rel;
      #Q scl = 1'b1;
      #Q if (i >= 0) q[i] = sda; else nak = sda;
      #Q scl = 1'b0;
    end
  endtask
endmodule

// file: dv/sensor_i2c_register_port_tb_top.sv
/*
  Self-checking bench of the sensor serial register port.
  Assumes the design, its checker and the i2c_host model are compiled first.
*/
`timescale 1ns/1ps
module sensor_i2c_register_port_tb_top;
  import sensor_i2c_pkg::*;
  logic clk = 1'b0;
  logic linkClk = 1'b0;
  logic rst_n = 1'b0;
  logic sclIn, sdaLow, sdaOut, sdaOe, intOut, intOe, alsIntEn, proxIntEn, alsProxMode, trimSel, alsGainMax14;
  logic alsEvent = 1'b0;
  logic proxEvent = 1'b0;
  logic [15:0] alsResult = 16'h0000;
  logic [7:0] proxResult = 8'h00;
  logic [7:0] mainCfg, rxCfg, txCfg, persistCfg, q;
  logic [7:0] sh [256];
  logic [7:0] wq [8];
  logic [31:0] rnd = 32'he8c1;
  logic nak;
  int n_errors = 0;
  int samples_checked = 0;
  wire sdaIn = (sdaOe ? sdaOut : 1'b1) & !sdaLow;
  // System clock and a free-running link clock of unrelated phase.
  always #25 clk = ~clk;
  initial begin
    #1.7;
    forever #3 linkClk = ~linkClk;
  end
  sensor_i2c_register_port i_sensor_i2c_register_port (
    .clk, .rst_n, .linkClk, .sclIn, .sdaIn, .sdaOut, .sdaOe, .intOut, .intOe, .alsEvent, .proxEvent,
    .alsResult, .proxResult, .mainCfg, .rxCfg, .txCfg, .persistCfg, .alsIntEn, .proxIntEn,
    .alsProxMode, .trimSel, .alsGainMax14
  );
  i2c_host i_i2c_host (.scl(sclIn), .sdaLow, .sda(sdaIn));
  // Next value of the bench's random sequence.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected read value of a register index.
  function automatic logic [7:0] expRd(input logic [7:0] a);
    if (a >= REG_RSVD_LO) return RD_BEYOND;
    if (a == REG_ALS_HI) return alsResult[15:8];
    if (a == REG_ALS_LO) return alsResult[7:0];
    if (a == REG_PROXIMITY) return proxResult;
    return sh[a];
  endfunction
  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One written byte and the device's answer on the ninth clock.
  task automatic bx(input logic [7:0] d, input logic e);
    i_i2c_host.xfer(d, 1'b1, q, nak);
    chk("ack", e, nak);
  endtask
  // Write frame: pointer byte, then n data bytes from wq.
  task automatic wr(input logic [7:0] p, input int n);
    i_i2c_host.start();
    bx(DEV_ADDR_WR, 1'b0);
    bx(p, 1'b0);
    for (int i = 0; i < n; i++) begin
      bx(wq[i], 1'b0);
      sh[p+i] = wq[i];
    end
    i_i2c_host.stop();
  endtask
  // Read frame of n bytes, from p after a repeated start when idx is set, else from zero.
  task automatic rd(input logic idx, input logic [7:0] p, input int n);
    int a;
    i_i2c_host.start();
    if (idx) begin
      bx(DEV_ADDR_WR, 1'b0);
      bx(p, 1'b0);
      i_i2c_host.start();
    end else begin
      p = 8'h00;
    end
    bx(DEV_ADDR_RD, 1'b0);
    for (int i = 0; i < n; i++) begin
      a = (p + i > 255) ? 255 : p + i;
      i_i2c_host.xfer(8'hff, i == n - 1, q, nak);
      chk("read data", expRd(a[7:0]), q);
      if (a == 0) sh[0] = 8'h00;
    end
    i_i2c_host.stop();
  endtask
  // One-cycle engine event pulses, then time for the pin to follow.
  task automatic pulse(input logic a, input logic p);
    @(posedge clk);
    alsEvent <= a;
    proxEvent <= p;
    @(posedge clk);
    alsEvent <= 1'b0;
    proxEvent <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected length of the run.
  initial begin
    #4ms;
    n_errors++;
    end_sim();
  end
  // Main sequence of scenarios.
  initial begin
    foreach (sh[i]) sh[i] = RD_UNMAPPED;
    sh[REG_STATUS] = {5'h00, RESET_STATUS};
    sh[REG_TRIM_G] = ~RESET_TRIM;
    sh[REG_TRIM_IR] = ~RESET_TRIM;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("intOe", 1'b0, intOe);
    chk("persistCfg", 8'h00, persistCfg);
    done("reset");
    rd(1'b0, 8'h00, 2);
    rd(1'b0, 8'h00, 1);
    done("plain read");
    for (int k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      i_i2c_host.start();
      bx(rnd[7:1] == DEV_ADDR_WR[7:1] ? 8'h96 : rnd[7:0], 1'b1);
      bx(REG_MAIN, 1'b1);
      i_i2c_host.stop();
    end
    i_i2c_host.start();
    bx(DEV_ADDR_WR, 1'b0);
    i_i2c_host.stop();
    done("foreign and early stop");
    for (int k = 0; k < 7; k++) begin
      rnd = lfsr(rnd);
      wq[k] = (k == 4) ? 8'h00 : rnd[7:0];
    end
    wr(8'h06, 7);
    chk("persistCfg", 8'h00, persistCfg);
    rnd = lfsr(rnd);
    wq[0] = 8'h13;
    wq[1] = 8'hf0;
    wq[2] = rnd[7:0];
    wr(REG_MAIN, 3);
    chk("mainCfg", 8'h13, mainCfg);
    chk("rxCfg", 8'hf0, rxCfg);
    chk("txCfg", rnd[7:0], txCfg);
    chk("modes", 8'h1b, {alsGainMax14, alsProxMode, trimSel, proxIntEn, alsIntEn});
    @(posedge clk);
    alsResult <= rnd[31:16];
    proxResult <= rnd[15:8];
    rd(1'b1, REG_MAIN, 5);
    rd(1'b1, REG_PROXIMITY, 1);
    rd(1'b1, 8'hfe, 3);
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      rd(1'b1, rnd[7:0] | 8'h01, 2);
    end
    done("indexed read");
    pulse(1'b1, 1'b0);
    chk("intOe", 1'b1, intOe);
    sh[REG_STATUS] = 8'h01;
    rd(1'b0, 8'h00, 1);
    chk("intOe", 1'b0, intOe);
    pulse(1'b0, 1'b1);
    chk("intOe", 1'b1, intOe);
    wq[0] = 8'h10;
    wr(REG_MAIN, 1);
    chk("intOe", 1'b0, intOe);
    rd(1'b0, 8'h00, 1);
    done("interrupt");
    end_sim();
  end
endmodule
